//--- svp_ctrl.sv
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module svp_ctrl (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  in_std,
   input  wire logic        frame_start,
   input  wire logic        cadence_ok,
   input  wire logic        pix_valid,
   input  wire logic [9:0]  pix_luma,
   input  wire logic [9:0]  pix_cb,
   input  wire logic [9:0]  pix_cr,
   output logic             pix_ready,
   output logic             out_valid,
   input  wire logic        out_ready,
   output logic [9:0]       out_luma,
   output logic [9:0]       out_cb,
   output logic [9:0]       out_cr,
   output logic             out_en,
   output logic             in_invalid,
   output logic [3:0]       out_fmt,
   output logic [2:0]       out_rate,
   output logic             out_pulldown
);
   // shadow registers written by software, plus the registered apb response (prdata, pready, pslverr)
   logic [31:0] ctrl_r, ctrl_nxt;
   logic [11:0] lgain_r, lgain_nxt, cgain_r, cgain_nxt;
   logic [11:0] lift_r, lift_nxt;
   logic [12:0] phase_r, phase_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   // active copies, loaded at frame boundary
   logic        a_en_r, a_en_nxt;
   logic [11:0] a_lg_r, a_lg_nxt, a_cg_r, a_cg_nxt, a_lift_r, a_lift_nxt;
   logic [12:0] a_ph_r, a_ph_nxt;
   logic [3:0]  fmt_r, fmt_nxt;
   logic [2:0]  rate_r, rate_nxt;
   logic        pd_r, pd_nxt, inv_r, inv_nxt, oen_r, oen_nxt;
   // input synchronisers
   logic [1:0]  std_s1, std_s2;
   logic        fs_s1, fs_s2, fs_d, cad_s1, cad_s2;
   // two-slot buffer, at most one word held
   logic [29:0] buf_q [0:1];
   logic [29:0] buf_q_nxt [0:1];
   logic [1:0]  cnt_r, cnt_nxt;
   logic        wsel;
   logic [29:0] proc_word;

   localparam int GAIN_UNITY_W = int'(svp_pkg::GAIN_UNITY);

   // negative sums floor at zero, large ones saturate
   function automatic logic [11:0] clamp12(input logic [31:0] v, input logic [11:0] mx);
      clamp12 = v[31] ? 12'h0 : ((v[11:0] > mx || v[30:12] != 19'h0) ? mx : v[11:0]);
   endfunction

   function automatic logic [9:0] gain10(input logic [9:0] x, input logic [11:0] g);
      logic [21:0] p;
      p = ({12'h0, x} * {10'h0, g}) / 22'(GAIN_UNITY_W);
      gain10 = (p > 22'h3ff) ? 10'h3ff : p[9:0];
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         std_s1 <= 2'h0;
         std_s2 <= 2'h0;
         fs_s1  <= 1'b0;
         fs_s2  <= 1'b0;
         fs_d   <= 1'b0;
         cad_s1 <= 1'b0;
         cad_s2 <= 1'b0;
      end else begin
         std_s1 <= in_std;
         std_s2 <= std_s1;
         fs_s1  <= frame_start;
         fs_s2  <= fs_s1;
         fs_d   <= fs_s2;
         cad_s1 <= cadence_ok;
         cad_s2 <= cad_s1;
      end
   end

   logic frame_edge;
   assign frame_edge = fs_s2 & ~fs_d;

   // apb slave, one wait-free access phase
   logic wr_acc, rd_acc;
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & ~penable & ~pwrite;

   always_comb begin
      ctrl_nxt    = ctrl_r;
      lgain_nxt   = lgain_r;
      cgain_nxt   = cgain_r;
      lift_nxt    = lift_r;
      phase_nxt   = phase_r;
      prdata_nxt  = prdata_r;
      pready_nxt  = psel & ~penable;
      pslverr_nxt = 1'b0;
      if (psel & ~penable) begin
         if (paddr == svp_pkg::ADDR_CTRL) begin
            prdata_nxt = ctrl_r;
         end else if (paddr == svp_pkg::ADDR_LGAIN) begin
            prdata_nxt = {20'h0, lgain_r};
         end else if (paddr == svp_pkg::ADDR_LIFT) begin
            prdata_nxt = {{20{lift_r[11]}}, lift_r};
         end else if (paddr == svp_pkg::ADDR_CGAIN) begin
            prdata_nxt = {20'h0, cgain_r};
         end else if (paddr == svp_pkg::ADDR_PHASE) begin
            prdata_nxt = {{19{phase_r[12]}}, phase_r};
         end else if (paddr == svp_pkg::ADDR_UNITY) begin
            prdata_nxt = 32'h0;
         end else if (paddr == svp_pkg::ADDR_STATUS) begin
            prdata_nxt = {21'h0, pd_r, rate_r, fmt_r, inv_r, oen_r, a_en_r};
         end else begin
            prdata_nxt  = 32'h0;
            pslverr_nxt = 1'b1;
         end
         if (rd_acc == 1'b0 && paddr == svp_pkg::ADDR_STATUS) begin
            pslverr_nxt = 1'b1;
         end
      end
      if (wr_acc) begin
         if (paddr == svp_pkg::ADDR_CTRL) begin
            ctrl_nxt = pwdata;
         end else if (paddr == svp_pkg::ADDR_LGAIN) begin
            lgain_nxt = clamp12(pwdata, svp_pkg::GAIN_MAX); // RQ3
            if (ctrl_r[svp_pkg::CTRL_GANG]) begin
               cgain_nxt = 12'(clamp12(32'(cgain_r) + pwdata - 32'(lgain_r), svp_pkg::GAIN_MAX)); // RQ7
            end
         end else if (paddr == svp_pkg::ADDR_CGAIN) begin
            cgain_nxt = clamp12(pwdata, svp_pkg::GAIN_MAX); // RQ5
            if (ctrl_r[svp_pkg::CTRL_GANG]) begin
               lgain_nxt = 12'(clamp12(32'(lgain_r) + pwdata - 32'(cgain_r), svp_pkg::GAIN_MAX)); // RQ7
            end
         end else if (paddr == svp_pkg::ADDR_LIFT) begin
            if ($signed(pwdata) > $signed({20'h0, svp_pkg::LIFT_MAX})) begin
               lift_nxt = svp_pkg::LIFT_MAX; // RQ4
            end else if ($signed(pwdata) < -$signed({20'h0, svp_pkg::LIFT_MAX})) begin
               lift_nxt = 12'(-svp_pkg::LIFT_MAX);
            end else begin
               lift_nxt = pwdata[11:0];
            end
         end else if (paddr == svp_pkg::ADDR_PHASE) begin
            if ($signed(pwdata) > $signed({19'h0, svp_pkg::PHASE_MAX})) begin
               phase_nxt = svp_pkg::PHASE_MAX; // RQ6
            end else if ($signed(pwdata) < -$signed({19'h0, svp_pkg::PHASE_MAX})) begin
               phase_nxt = 13'(-svp_pkg::PHASE_MAX);
            end else begin
               phase_nxt = pwdata[12:0];
            end
         end else if (paddr == svp_pkg::ADDR_UNITY) begin
            if (pwdata[1:0] == svp_pkg::UNITY_YES) begin
               lgain_nxt = svp_pkg::GAIN_UNITY; // RQ2
               cgain_nxt = svp_pkg::GAIN_UNITY;
               lift_nxt  = 12'h0;
               phase_nxt = 13'h0;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r    <= svp_pkg::CTRL_RST;
         lgain_r   <= svp_pkg::GAIN_UNITY;
         cgain_r   <= svp_pkg::GAIN_UNITY;
         lift_r    <= 12'h0;
         phase_r   <= 13'h0;
         prdata_r  <= 32'h0;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         ctrl_r    <= ctrl_nxt;
         lgain_r   <= lgain_nxt;
         cgain_r   <= cgain_nxt;
         lift_r    <= lift_nxt;
         phase_r   <= phase_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // format selection and frame-boundary update
   always_comb begin
      logic [2:0] tgt;
      logic       is525;
      tgt        = ctrl_r[svp_pkg::CTRL_TGT_LSB +: svp_pkg::TGT_W];
      is525      = (std_s2 == svp_pkg::IN_525);
      a_en_nxt   = a_en_r;
      a_lg_nxt   = a_lg_r;
      a_cg_nxt   = a_cg_r;
      a_lift_nxt = a_lift_r;
      a_ph_nxt   = a_ph_r;
      fmt_nxt    = fmt_r;
      rate_nxt   = rate_r;
      pd_nxt     = pd_r;
      inv_nxt    = inv_r;
      oen_nxt    = oen_r;
      if (frame_edge) begin
         a_en_nxt   = ctrl_r[svp_pkg::CTRL_PROC_EN]; // RQ16
         a_lg_nxt   = lgain_r;
         a_cg_nxt   = cgain_r;
         a_lift_nxt = lift_r;
         a_ph_nxt   = phase_r;
         pd_nxt     = 1'b0;
         inv_nxt    = 1'b0;
         oen_nxt    = 1'b1;
         fmt_nxt    = svp_pkg::FMT_NONE;
         rate_nxt   = svp_pkg::RATE_NONE;
         if (std_s2 != svp_pkg::IN_525 && std_s2 != svp_pkg::IN_625) begin
            inv_nxt = 1'b1; // RQ12
            oen_nxt = 1'b0;
         end else begin
            case (tgt)
               svp_pkg::TGT_SAME: begin
                  fmt_nxt  = is525 ? svp_pkg::FMT_525I : svp_pkg::FMT_625I; // RQ10
                  rate_nxt = is525 ? svp_pkg::RATE_5994 : svp_pkg::RATE_50;
               end
               svp_pkg::TGT_720P: begin
                  fmt_nxt = svp_pkg::FMT_720P; // RQ8 RQ9
                  if (ctrl_r[svp_pkg::CTRL_HALF]) begin
                     rate_nxt = is525 ? svp_pkg::RATE_2997 : svp_pkg::RATE_25; // RQ13
                  end else begin
                     rate_nxt = is525 ? svp_pkg::RATE_5994 : svp_pkg::RATE_50;
                  end
               end
               svp_pkg::TGT_1080I: begin
                  fmt_nxt  = svp_pkg::FMT_1080I; // RQ15
                  rate_nxt = is525 ? svp_pkg::RATE_5994 : svp_pkg::RATE_50;
               end
               svp_pkg::TGT_1080P: begin
                  fmt_nxt  = svp_pkg::FMT_1080P;
                  rate_nxt = is525 ? svp_pkg::RATE_2997 : svp_pkg::RATE_25;
               end
               svp_pkg::TGT_720F, svp_pkg::TGT_1080F: begin
                  if (is525) begin
                     rate_nxt = svp_pkg::RATE_2398;
                     pd_nxt   = cad_s2; // RQ11
                     if (tgt == svp_pkg::TGT_720F) begin
                        fmt_nxt = svp_pkg::FMT_720P;
                     end else if (ctrl_r[svp_pkg::CTRL_PSF]) begin
                        fmt_nxt = svp_pkg::FMT_1080PSF; // RQ14
                     end else begin
                        fmt_nxt = svp_pkg::FMT_1080P;
                     end
                  end else begin
                     inv_nxt = 1'b1; // RQ9
                     oen_nxt = 1'b0;
                  end
               end
               default: begin
                  inv_nxt = 1'b1;
                  oen_nxt = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_en_r   <= 1'b0;
         a_lg_r   <= svp_pkg::GAIN_UNITY;
         a_cg_r   <= svp_pkg::GAIN_UNITY;
         a_lift_r <= 12'h0;
         a_ph_r   <= 13'h0;
         fmt_r    <= svp_pkg::FMT_NONE;
         rate_r   <= svp_pkg::RATE_NONE;
         pd_r     <= 1'b0;
         inv_r    <= 1'b0;
         oen_r    <= 1'b0;
      end else begin
         a_en_r   <= a_en_nxt;
         a_lg_r   <= a_lg_nxt;
         a_cg_r   <= a_cg_nxt;
         a_lift_r <= a_lift_nxt;
         a_ph_r   <= a_ph_nxt;
         fmt_r    <= fmt_nxt;
         rate_r   <= rate_nxt;
         pd_r     <= pd_nxt;
         inv_r    <= inv_nxt;
         oen_r    <= oen_nxt;
      end
   end

   // pixel path: gain, lift, chroma gain; phase needs sin/cos, left to scaler
   always_comb begin
      logic [9:0]  y, cb, cr;
      logic [12:0] yl;
      y  = gain10(pix_luma, a_lg_r); // RQ3
      yl = 13'({3'h0, y}) + 13'({a_lift_r[11], a_lift_r}); // RQ4
      y  = yl[12] ? 10'h0 : (yl > 13'h3ff ? 10'h3ff : yl[9:0]);
      cb = gain10(pix_cb, a_cg_r); // RQ5
      cr = gain10(pix_cr, a_cg_r);
      if (a_en_r) begin
         proc_word = {y, cb, cr}; // RQ1
      end else begin
         proc_word = {pix_luma, pix_cb, pix_cr};
      end
   end

   // buffer holds at most one word, stall via pix_ready while it holds one
   logic push, pop;
   assign push = pix_valid & pix_ready & oen_r;
   assign pop  = out_valid & out_ready;
   assign wsel = (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) ? 1'b0 : 1'b1;

   always_comb begin
      buf_q_nxt[0] = buf_q[0];
      buf_q_nxt[1] = buf_q[1];
      cnt_nxt      = cnt_r;
      if (pop) begin
         buf_q_nxt[0] = buf_q[1];
      end
      if (push) begin
         buf_q_nxt[wsel] = proc_word;
      end
      cnt_nxt = cnt_r + 2'(push) - 2'(pop);
   end

   logic pix_ready_r;
   logic out_valid_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_q[0]    <= 30'h0;
         buf_q[1]    <= 30'h0;
         cnt_r       <= 2'h0;
         pix_ready_r <= 1'b0;
         out_valid_r <= 1'b0;
      end else begin
         buf_q[0]    <= buf_q_nxt[0];
         buf_q[1]    <= buf_q_nxt[1];
         cnt_r       <= cnt_nxt;
         pix_ready_r <= (cnt_nxt == 2'h0);
         out_valid_r <= (cnt_nxt != 2'h0);
      end
   end

   assign pix_ready    = pix_ready_r;
   assign out_valid    = out_valid_r;
   assign out_luma     = buf_q[0][29:20];
   assign out_cb       = buf_q[0][19:10];
   assign out_cr       = buf_q[0][9:0];
   assign prdata       = prdata_r;
   assign pready       = pready_r;
   assign pslverr      = pslverr_r;
   assign out_en       = oen_r;
   assign in_invalid   = inv_r;
   assign out_fmt      = fmt_r;
   assign out_rate     = rate_r;
   assign out_pulldown = pd_r;
endmodule // svp_ctrl

//--- svp_ctrl_properties.sv
`timescale 1ns/1ps
module svp_ctrl_properties (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       frame_start,
   input wire logic       pix_valid,
   input wire logic       pix_ready,
   input wire logic       out_valid,
   input wire logic       out_ready,
   input wire logic [9:0] out_luma,
   input wire logic       out_en,
   input wire logic       in_invalid,
   input wire logic [3:0] out_fmt,
   input wire logic [2:0] out_rate,
   input wire logic       out_pulldown
);
   logic [3:0] since_r;
   logic [3:0] since_nxt;
   logic       fs_q_r;
   // cycles since the raw frame pin last rose
   always_comb begin
      since_nxt = (since_r == 4'hf) ? since_r : since_r + 4'h1;
      if (frame_start && !fs_q_r) since_nxt = 4'h0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         since_r <= 4'hf;
         fs_q_r  <= 1'b0;
      end else begin
         since_r <= since_nxt;
         fs_q_r  <= frame_start;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_access_a: assert property (psel && penable |-> pready) else $error("no answer in access");
   err_ready_a: assert property (pslverr |-> pready && psel && penable) else $error("stray error");
   accept_next_a: assert property (pix_valid && pix_ready && out_en |=> out_valid) else $error("word lost");
   hold_out_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_luma)) else $error("word dropped");
   invalid_off_a: assert property (in_invalid |-> !out_en) else $error("output on while invalid");
   psf_rate_a: assert property (out_fmt == svp_pkg::FMT_1080PSF |-> out_rate == svp_pkg::RATE_2398)
      else $error("segmented frame rate");
   field_rate_a: assert property (out_fmt == svp_pkg::FMT_1080I |->
      out_rate == svp_pkg::RATE_5994 || out_rate == svp_pkg::RATE_50) else $error("interlaced rate");
   pulldown_film_a: assert property (out_pulldown |-> out_en && out_rate == svp_pkg::RATE_2398)
      else $error("pulldown off film");
   same_rate_a: assert property (out_fmt == svp_pkg::FMT_525I |-> out_rate == svp_pkg::RATE_5994)
      else $error("pass rate");
   frame_edge_a: assert property (out_en && $past(out_en) && $changed(out_rate) |-> since_r <= 4'h6)
      else $error("change off frame");
endmodule // svp_ctrl_properties
bind svp_ctrl svp_ctrl_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .frame_start(frame_start), .pix_valid(pix_valid),
   .pix_ready(pix_ready), .out_valid(out_valid), .out_ready(out_ready), .out_luma(out_luma),
   .out_en(out_en), .in_invalid(in_invalid), .out_fmt(out_fmt), .out_rate(out_rate),
   .out_pulldown(out_pulldown));

//--- svp_pkg.sv
// Functional notes
// RQ1: master switch bypasses or applies all adjustments; the code applies gain, lift and chroma gain but not phase
// RQ2: confirmed unity reset restores neutral; reject keeps
// RQ3: luma gain 0 to 200 percent, 0.1 steps
// RQ4: luma lift -100 to 100 percent, 0.1 steps
// RQ5: chroma gain 0 to 200 percent, 0.1 steps
// RQ6: chroma phase -360 to 360 degrees, 0.1 steps
// RQ7: ganged gain moves luma and chroma equally
// RQ8: 525 input converts to listed 59.94 family outputs
// RQ9: 625 input converts to listed 50 outputs only
// RQ10: pass-through keeps input format and rate
// RQ11: film rates use 3-2 pulldown, else deinterlace
// RQ12: other inputs flag invalid and disable output
// RQ13: 720p half-rate option halves frame rate
// RQ14: PsF option carries 1080 film as segments
// RQ15: interlaced rates are fields, progressive are frames
// RQ16: settings take effect only at frame boundary
package svp_pkg;
   localparam logic [11:0] ADDR_CTRL    = 12'h000;
   localparam logic [11:0] ADDR_LGAIN   = 12'h004;
   localparam logic [11:0] ADDR_LIFT    = 12'h008;
   localparam logic [11:0] ADDR_CGAIN   = 12'h00c;
   localparam logic [11:0] ADDR_PHASE   = 12'h010;
   localparam logic [11:0] ADDR_UNITY   = 12'h014;
   localparam logic [11:0] ADDR_STATUS  = 12'h018;
   // ctrl fields
   localparam int CTRL_PROC_EN  = 0;
   localparam int CTRL_GANG     = 1;
   localparam int CTRL_HALF     = 2;
   localparam int CTRL_PSF      = 3;
   localparam int CTRL_TGT_LSB  = 4;
   localparam int TGT_W         = 3;
   // unity command codes
   localparam logic [1:0] UNITY_YES = 2'h1;
   localparam logic [1:0] UNITY_NO  = 2'h2;
   // gain and lift in 0.1 units
   localparam logic [11:0] GAIN_UNITY = 12'h3e8;
   localparam logic [11:0] GAIN_MAX   = 12'h7d0;
   localparam logic [11:0] LIFT_MAX   = 12'h3e8;
   localparam logic [12:0] PHASE_MAX  = 13'he10;
   localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
   // conversion targets
   typedef enum logic [2:0] {
      TGT_SAME = 3'h0, TGT_720P = 3'h1, TGT_720F = 3'h2, TGT_1080I = 3'h3,
      TGT_1080P = 3'h4, TGT_1080F = 3'h5
   } svp_tgt_t;
   // output formats
   typedef enum logic [3:0] {
      FMT_NONE = 4'h0, FMT_525I = 4'h1, FMT_625I = 4'h2, FMT_720P = 4'h3,
      FMT_1080I = 4'h4, FMT_1080P = 4'h5, FMT_1080PSF = 4'h6
   } svp_fmt_t;
   // rates, field for interlaced and frame for progressive
   typedef enum logic [2:0] {
      RATE_NONE = 3'h0, RATE_5994 = 3'h1, RATE_2997 = 3'h2, RATE_2398 = 3'h3,
      RATE_50 = 3'h4, RATE_25 = 3'h5
   } svp_rate_t;
   // input standard codes from the detector
   localparam logic [1:0] IN_525 = 2'h1;
   localparam logic [1:0] IN_625 = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001, ST_SETUP = 3'b010, ST_ACCESS = 3'b100
   } svp_bus_t;
endpackage

//--- svp_video_model.sv
`timescale 1ns/1ps
module svp_video_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        go,
   input  wire logic        slow,
   input  wire logic        pix_ready,
   output logic             pix_valid,
   output logic [9:0]       pix_luma,
   output logic [9:0]       pix_cb,
   output logic [9:0]       pix_cr,
   input  wire logic        out_valid,
   output logic             out_ready,
   input  wire logic [9:0]  out_luma,
   input  wire logic [9:0]  out_cb,
   input  wire logic [9:0]  out_cr,
   output logic [15:0]      tx_cnt,
   output logic [15:0]      rx_cnt,
   output logic [15:0]      rx_err
);
   logic [9:0] seq_r;
   logic [9:0] exp_r;
   // idle lines show the inverse so stale data never looks valid
   assign pix_luma = pix_valid ? seq_r : ~seq_r;
   assign pix_cb   = pix_valid ? ~seq_r : seq_r;
   assign pix_cr   = pix_valid ? (seq_r ^ 10'h155) : ~(seq_r ^ 10'h155);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pix_valid <= 1'b0;
         out_ready <= 1'b0;
         seq_r     <= 10'h0;
         exp_r     <= 10'h0;
         tx_cnt    <= 16'h0;
         rx_cnt    <= 16'h0;
         rx_err    <= 16'h0;
      end else begin
         if (pix_valid && pix_ready) begin
            seq_r     <= seq_r + 10'h1;
            tx_cnt    <= tx_cnt + 16'h1;
            pix_valid <= go;
         end else if (!pix_valid) begin
            pix_valid <= go;
         end
         out_ready <= slow ? ~out_ready : 1'b1;
         if (out_valid && out_ready) begin
            exp_r  <= exp_r + 10'h1;
            rx_cnt <= rx_cnt + 16'h1;
            if (out_luma !== exp_r || out_cb !== ~exp_r || out_cr !== (exp_r ^ 10'h155)) rx_err <= rx_err + 16'h1;
         end
      end
   end
endmodule // svp_video_model

//--- test_svp_ctrl.sv
`timescale 1ns/1ps
module test_svp_ctrl;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, go, slow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  in_std;
   logic        frame_start, cadence_ok, pix_valid, pix_ready, out_valid, out_ready;
   logic [9:0]  pix_luma, pix_cb, pix_cr, out_luma, out_cb, out_cr;
   logic        out_en, in_invalid, out_pulldown;
   logic [3:0]  out_fmt;
   logic [2:0]  out_rate;
   logic [15:0] tx_cnt, rx_cnt, rx_err;
   int          n_mismatch, total_checks;
   svp_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .in_std(in_std), .frame_start(frame_start), .cadence_ok(cadence_ok), .pix_valid(pix_valid),
      .pix_luma(pix_luma), .pix_cb(pix_cb), .pix_cr(pix_cr), .pix_ready(pix_ready), .out_valid(out_valid),
      .out_ready(out_ready), .out_luma(out_luma), .out_cb(out_cb), .out_cr(out_cr), .out_en(out_en),
      .in_invalid(in_invalid), .out_fmt(out_fmt), .out_rate(out_rate), .out_pulldown(out_pulldown));
   svp_video_model vm (.pclk(pclk), .presetn(presetn), .go(go), .slow(slow), .pix_ready(pix_ready),
      .pix_valid(pix_valid), .pix_luma(pix_luma), .pix_cb(pix_cb), .pix_cr(pix_cr), .out_valid(out_valid),
      .out_ready(out_ready), .out_luma(out_luma), .out_cb(out_cb), .out_cr(out_cr), .tx_cnt(tx_cnt),
      .rx_cnt(rx_cnt), .rx_err(rx_err));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task print_verdict;
      if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // entered right after a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, e);
   endtask
   task frame;
      frame_start <= 1'b1;
      repeat (4) @(posedge pclk);
      frame_start <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask
   task stream(input logic [15:0] n);
      logic [15:0] t0;
      t0 = tx_cnt;
      go <= 1'b1;
      while (tx_cnt < t0 + n) @(posedge pclk);
      go <= 1'b0;
      do @(posedge pclk); while (pix_valid || rx_cnt !== tx_cnt);
      chk("stream data", 32'(rx_err), 32'h0);
   endtask
   task conv(input logic [1:0] s, input logic [2:0] t, input logic h, input logic p,
             input svp_pkg::svp_fmt_t f, input svp_pkg::svp_rate_t r);
      in_std <= s;
      apb(1'b1, svp_pkg::ADDR_CTRL, {25'h0, t, p, h, 2'h1});
      frame();
      chk("out_en", 32'(out_en), 32'(f != svp_pkg::FMT_NONE));
      if (f == svp_pkg::FMT_NONE) chk("in_invalid", 32'(in_invalid), 32'h1);
      else begin
         chk("out_fmt", 32'(out_fmt), 32'(f));
         chk("out_rate", 32'(out_rate), 32'(r));
      end
   endtask
   task t_regs;
      rdchk("ctrl", svp_pkg::ADDR_CTRL, svp_pkg::CTRL_RST);
      rdchk("lgain", svp_pkg::ADDR_LGAIN, {20'h0, svp_pkg::GAIN_UNITY});
      rdchk("lift", svp_pkg::ADDR_LIFT, 32'h0);
      rdchk("cgain", svp_pkg::ADDR_CGAIN, {20'h0, svp_pkg::GAIN_UNITY});
      rdchk("phase", svp_pkg::ADDR_PHASE, 32'h0);
      apb(1'b0, 12'h01c, 32'h0);
      chk("unmapped", 32'(er), 32'h1);
   endtask
   task t_gain;
      apb(1'b1, svp_pkg::ADDR_LGAIN, 32'h5dc);
      rdchk("cgain solo", svp_pkg::ADDR_CGAIN, 32'h3e8);
      apb(1'b1, svp_pkg::ADDR_CTRL, 32'h3);
      apb(1'b1, svp_pkg::ADDR_LGAIN, 32'h4b0);
      rdchk("cgain gang", svp_pkg::ADDR_CGAIN, 32'h2bc);
      apb(1'b1, svp_pkg::ADDR_CGAIN, 32'h320);
      rdchk("lgain gang", svp_pkg::ADDR_LGAIN, 32'h514);
      apb(1'b1, svp_pkg::ADDR_CTRL, 32'h1);
      apb(1'b1, svp_pkg::ADDR_LGAIN, 32'hfff);
      rdchk("lgain max", svp_pkg::ADDR_LGAIN, {20'h0, svp_pkg::GAIN_MAX});
      apb(1'b1, svp_pkg::ADDR_LIFT, 32'h64);
      apb(1'b1, svp_pkg::ADDR_PHASE, 32'hffff_f000);
      rdchk("phase min", svp_pkg::ADDR_PHASE, 32'hffff_f1f0);
      apb(1'b1, svp_pkg::ADDR_UNITY, {30'h0, svp_pkg::UNITY_NO});
      rdchk("lift kept", svp_pkg::ADDR_LIFT, 32'h64);
      apb(1'b1, svp_pkg::ADDR_UNITY, {30'h0, svp_pkg::UNITY_YES});
      rdchk("lgain unity", svp_pkg::ADDR_LGAIN, {20'h0, svp_pkg::GAIN_UNITY});
      rdchk("cgain unity", svp_pkg::ADDR_CGAIN, {20'h0, svp_pkg::GAIN_UNITY});
      rdchk("lift null", svp_pkg::ADDR_LIFT, 32'h0);
      rdchk("phase null", svp_pkg::ADDR_PHASE, 32'h0);
   endtask
   task t_video;
      conv(svp_pkg::IN_525, 3'h0, 1'b0, 1'b0, svp_pkg::FMT_525I, svp_pkg::RATE_5994);
      apb(1'b1, svp_pkg::ADDR_LGAIN, 32'h1f4);
      apb(1'b1, svp_pkg::ADDR_CTRL, 32'h0);
      frame();
      slow <= 1'b1;
      stream(16'h8);
      apb(1'b1, svp_pkg::ADDR_UNITY, {30'h0, svp_pkg::UNITY_YES});
      apb(1'b1, svp_pkg::ADDR_CTRL, 32'h1);
      frame();
      slow <= 1'b0;
      stream(16'h8);
   endtask
   task t_conv;
      apb(1'b1, svp_pkg::ADDR_CTRL, 32'h31);
      repeat (8) @(posedge pclk);
      chk("fmt held", 32'(out_fmt), 32'(svp_pkg::FMT_525I));
      conv(svp_pkg::IN_525, 3'h1, 1'b0, 1'b0, svp_pkg::FMT_720P, svp_pkg::RATE_5994);
      conv(svp_pkg::IN_525, 3'h1, 1'b1, 1'b0, svp_pkg::FMT_720P, svp_pkg::RATE_2997);
      conv(svp_pkg::IN_525, 3'h2, 1'b0, 1'b0, svp_pkg::FMT_720P, svp_pkg::RATE_2398);
      conv(svp_pkg::IN_525, 3'h3, 1'b0, 1'b0, svp_pkg::FMT_1080I, svp_pkg::RATE_5994);
      conv(svp_pkg::IN_525, 3'h4, 1'b0, 1'b0, svp_pkg::FMT_1080P, svp_pkg::RATE_2997);
      conv(svp_pkg::IN_525, 3'h5, 1'b0, 1'b1, svp_pkg::FMT_1080PSF, svp_pkg::RATE_2398);
      conv(svp_pkg::IN_525, 3'h5, 1'b0, 1'b0, svp_pkg::FMT_1080P, svp_pkg::RATE_2398);
      chk("pulldown", 32'(out_pulldown), 32'h1);
      cadence_ok <= 1'b0;
      frame();
      chk("no cadence", {out_en, out_pulldown, out_fmt}, {2'h2, svp_pkg::FMT_1080P});
      cadence_ok <= 1'b1;
      conv(svp_pkg::IN_625, 3'h0, 1'b0, 1'b0, svp_pkg::FMT_625I, svp_pkg::RATE_50);
      conv(svp_pkg::IN_625, 3'h1, 1'b0, 1'b0, svp_pkg::FMT_720P, svp_pkg::RATE_50);
      conv(svp_pkg::IN_625, 3'h1, 1'b1, 1'b0, svp_pkg::FMT_720P, svp_pkg::RATE_25);
      conv(svp_pkg::IN_625, 3'h3, 1'b0, 1'b0, svp_pkg::FMT_1080I, svp_pkg::RATE_50);
      conv(svp_pkg::IN_625, 3'h4, 1'b0, 1'b0, svp_pkg::FMT_1080P, svp_pkg::RATE_25);
      conv(svp_pkg::IN_625, 3'h2, 1'b0, 1'b0, svp_pkg::FMT_NONE, svp_pkg::RATE_NONE);
      conv(svp_pkg::IN_625, 3'h5, 1'b0, 1'b1, svp_pkg::FMT_NONE, svp_pkg::RATE_NONE);
      conv(2'h3, 3'h0, 1'b0, 1'b0, svp_pkg::FMT_NONE, svp_pkg::RATE_NONE);
      conv(2'h0, 3'h1, 1'b0, 1'b0, svp_pkg::FMT_NONE, svp_pkg::RATE_NONE);
      rdchk("status", svp_pkg::ADDR_STATUS, 32'h5);
   endtask
   initial begin
      repeat (40000) @(posedge pclk);
      n_mismatch++;
      print_verdict();
   end
   initial begin
      {presetn, psel, penable, pwrite, go, slow, frame_start} = 7'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      in_std = svp_pkg::IN_525;
      cadence_ok = 1'b1;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_gain();
      t_video();
      t_conv();
      print_verdict();
   end
endmodule // test_svp_ctrl
